// File: hw/motion_alarm_regs.vh
`ifndef MOTION_ALARM_REGS_VH
`define MOTION_ALARM_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define REG_CTRL 12'h000
`define REG_CMD 12'h004
`define REG_STATUS 12'h008
`define REG_SOFT_POS 12'h00C
`define REG_SOFT_NEG 12'h010

// ==========================================================
// Control fields and reset values
`define CTRL_POL_BIT 0
`define CTRL_HTYPE_LO 1
`define CTRL_HTYPE_HI 2
`define CTRL_STOPACT_BIT 3
`define CTRL_SOFTEN_BIT 4
`define CTRL_RESET 5'h00
`define SOFT_POS_RESET 32'h7FFFFFFF
`define SOFT_NEG_RESET 32'h80000000

// ==========================================================
// Command and status fields
`define CMD_CLEAR_BIT 0
`define CMD_SYSRST_BIT 1
`define STAT_ACTIVE_BIT 8
`define STAT_TORQUE_BIT 9
`define STAT_FATAL_BIT 10

// ==========================================================
// Home seek types
`define HTYPE_HOME 2'h0
`define HTYPE_TIM 2'h1
`define HTYPE_SENS 2'h2
`define HTYPE_BOTH 2'h3

// ==========================================================
// Alarm codes
`define ALM_LS_LOGIC 8'h60
`define ALM_LS_REV 8'h61
`define ALM_HOME_FAIL 8'h62
`define ALM_HOME_MISS 8'h63
`define ALM_TIM_SENS 8'h64
`define ALM_OFS_LS 8'h6A
`define ALM_DRV_ALM 8'h6E
`define ALM_DRV_CONN 8'h6F
`define ALM_MOT_PARAM 8'h70
`define ALM_PANIC 8'h68
`define ALM_HW_OT 8'h66
`define ALM_SW_OT 8'h67
`define ALM_NVM 8'h41
`define ALM_SYS 8'hF0
`define ALM_MEM 8'hF1
`define ALM_SEQ 8'hF2

// ==========================================================
// Blink counts
`define BLINK_STOP 4'h7
`define BLINK_PANIC 4'h6
`define BLINK_OT 4'h7
`define BLINK_NVM 4'h9

// ==========================================================
// Timing
`define CLK_KHZ 10000
`define LED_ON_MS 200
`define LED_OFF_MS 300
`define LED_PAUSE_MS 1500
`define DRV_TIMEOUT_MS 10
`define UNSTABLE_EDGES 2'h3

`endif

// File: hw/sync_two_stage.v
`timescale 1ns/1ps
// ==========================================================
// Two flip-flop synchroniser
module sync_two_stage #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Data
  input wire [WIDTH-1:0] din,
  output reg [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {WIDTH{1'b0}};
      dout <= {WIDTH{1'b0}};
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

// File: hw/motion_alarm_monitor.v
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "motion_alarm_regs.vh"

module motion_alarm_monitor #(
  parameter LED_ON_CYC = `LED_ON_MS * `CLK_KHZ,
  parameter LED_OFF_CYC = `LED_OFF_MS * `CLK_KHZ,
  parameter LED_PAUSE_CYC = `LED_PAUSE_MS * `CLK_KHZ,
  parameter DRV_TIMEOUT_CYC = `DRV_TIMEOUT_MS * `CLK_KHZ
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Axis and driver pins
  input wire travelLimitPos,
  input wire travelLimitNeg,
  input wire homePositionSensor,
  input wire stepTimingSignal,
  input wire sensorInput,
  input wire driverAlarm,
  input wire driverAck,
  input wire panicHaltRequest,
  // Sequence interpreter
  input wire homeSeekActive,
  input wire homeSeekDirPos,
  input wire homeSeekEnd,
  input wire offsetMoveActive,
  input wire driverCmdIssue,
  input wire moveStart,
  input wire currentEnabled,
  input wire homeInputsMissing,
  input wire linkDirMixed,
  input wire panicCmd,
  input wire [31:0] commandedPos,
  input wire nvmCorrupt,
  input wire logicStateFault,
  input wire memAccessFault,
  input wire seqCodeFault,
  // Alarm outputs
  output reg [7:0] alarmCode_q,
  output reg alarmActive_q,
  output reg motionHalt_q,
  output reg sequenceStop_q,
  output reg holdTorque_q,
  output reg driverCmdCancel_q,
  output reg alarmLed_q
);
  // ==========================================================
  // Pin synchronisation
  wire [7:0] pinSync;

  sync_two_stage #(.WIDTH(8)) pinSyncInst (
    .clk(clk),
    .rst(rst),
    .din({panicHaltRequest, driverAck, driverAlarm, sensorInput,
          stepTimingSignal, homePositionSensor, travelLimitNeg,
          travelLimitPos}),
    .dout(pinSync)
  );

  // ==========================================================
  // Registers
  reg [4:0] ctrl_q;
  reg [31:0] softPos_q;
  reg [31:0] softNeg_q;
  wire limitSensorPolarity = ctrl_q[`CTRL_POL_BIT];
  wire [1:0] homeSeekType = ctrl_q[`CTRL_HTYPE_HI:`CTRL_HTYPE_LO];
  wire alarmStopAction = ctrl_q[`CTRL_STOPACT_BIT];
  wire softLimitEn = ctrl_q[`CTRL_SOFTEN_BIT];

  wire limPos = pinSync[0] ^ limitSensorPolarity;
  wire limNeg = pinSync[1] ^ limitSensorPolarity;
  wire homeIn = pinSync[2];
  wire timIn = pinSync[3];
  wire sensIn = pinSync[4];
  wire drvAlm = pinSync[5];
  wire drvAck = pinSync[6];
  wire panicIn = pinSync[7];

  // ==========================================================
  // APB slave, no wait states
  wire setup = psel & ~penable;
  wire wrStb = psel & penable & pready & pwrite;
  wire clearCmd = wrStb && paddr == `REG_CMD && pwdata[`CMD_CLEAR_BIT];
  wire sysResetCmd = wrStb && paddr == `REG_CMD &&
                     pwdata[`CMD_SYSRST_BIT];
  wire fatalCur;
  reg [31:0] rdData;
  reg addrOk;

  always @* begin
    rdData = 32'h00000000;
    addrOk = 1'b1;
    if (paddr == `REG_CTRL) begin
      rdData = {27'h0000000, ctrl_q};
    end else if (paddr == `REG_CMD) begin
      rdData = 32'h00000000;
    end else if (paddr == `REG_STATUS) begin
      rdData = {21'h000000, fatalCur, holdTorque_q, alarmActive_q,
                alarmCode_q};
    end else if (paddr == `REG_SOFT_POS) begin
      rdData = softPos_q;
    end else if (paddr == `REG_SOFT_NEG) begin
      rdData = softNeg_q;
    end else begin
      addrOk = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_q <= `CTRL_RESET;
      softPos_q <= `SOFT_POS_RESET;
      softNeg_q <= `SOFT_NEG_RESET;
    end else begin
      pready <= setup;
      pslverr <= setup & ~addrOk;
      prdata <= (setup && !pwrite) ? rdData : 32'h00000000;
      if (wrStb && paddr == `REG_CTRL) begin
        ctrl_q <= pwdata[4:0];
      end
      if (wrStb && paddr == `REG_SOFT_POS) begin
        softPos_q <= pwdata;
      end
      if (wrStb && paddr == `REG_SOFT_NEG) begin
        softNeg_q <= pwdata;
      end
    end
  end

  // ==========================================================
  // Home seek tracking
  reg seekPrev_q;
  reg limPosPrev_q;
  reg limNegPrev_q;
  reg seenPos_q;
  reg seenNeg_q;
  reg seenHome_q;
  reg coincide_q;
  reg [1:0] edgeCnt_q;
  wire seekStart = homeSeekActive & ~seekPrev_q;
  wire limEdge = (limPos & ~limPosPrev_q) | (limNeg & ~limNegPrev_q);
  reg needMet;

  always @* begin
    needMet = 1'b1;
    case (homeSeekType)
      `HTYPE_TIM: needMet = timIn;
      `HTYPE_SENS: needMet = sensIn;
      `HTYPE_BOTH: needMet = timIn & sensIn;
      default: needMet = 1'b1;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      seekPrev_q <= 1'b0;
      limPosPrev_q <= 1'b0;
      limNegPrev_q <= 1'b0;
      seenPos_q <= 1'b0;
      seenNeg_q <= 1'b0;
      seenHome_q <= 1'b0;
      coincide_q <= 1'b0;
      edgeCnt_q <= 2'h0;
    end else begin
      seekPrev_q <= homeSeekActive;
      limPosPrev_q <= limPos;
      limNegPrev_q <= limNeg;
      if (seekStart) begin
        seenPos_q <= 1'b0;
        seenNeg_q <= 1'b0;
        seenHome_q <= 1'b0;
        coincide_q <= 1'b0;
        edgeCnt_q <= 2'h0;
      end else if (homeSeekActive) begin
        seenPos_q <= seenPos_q | limPos;
        seenNeg_q <= seenNeg_q | limNeg;
        seenHome_q <= seenHome_q | homeIn;
        coincide_q <= coincide_q | (homeIn & needMet);
        if (limEdge && edgeCnt_q != `UNSTABLE_EDGES) begin
          edgeCnt_q <= edgeCnt_q + 2'h1;
        end
      end else begin
        seenPos_q <= 1'b0;
        seenNeg_q <= 1'b0;
        seenHome_q <= 1'b0;
        edgeCnt_q <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Driver response watchdog
  reg waitAck_q;
  reg [31:0] ackTimer_q;
  wire drvTimeout = waitAck_q && !drvAck &&
                    ackTimer_q == DRV_TIMEOUT_CYC - 1;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      waitAck_q <= 1'b0;
      ackTimer_q <= 32'h00000000;
      driverCmdCancel_q <= 1'b0;
    end else begin
      driverCmdCancel_q <= drvTimeout;
      if (drvAck || drvTimeout) begin
        waitAck_q <= 1'b0;
        ackTimer_q <= 32'h00000000;
      end else if (driverCmdIssue && !waitAck_q) begin
        waitAck_q <= 1'b1;
        ackTimer_q <= 32'h00000000;
      end else if (waitAck_q) begin
        ackTimer_q <= ackTimer_q + 32'h00000001;
      end
    end
  end

  // ==========================================================
  // Alarm detection, highest priority first
  reg [7:0] newCode;
  reg newValid;
  wire newFatal = newCode == `ALM_NVM || newCode[7:4] == 4'hF;
  wire anyLim = limPos | limNeg;
  wire softOut = softLimitEn &&
                 ($signed(commandedPos) > $signed(softPos_q) ||
                  $signed(commandedPos) < $signed(softNeg_q));

  always @* begin
    newValid = 1'b1;
    newCode = 8'h00;
    if (logicStateFault) begin
      newCode = `ALM_SYS;
    end else if (memAccessFault) begin
      newCode = `ALM_MEM;
    end else if (seqCodeFault) begin
      newCode = `ALM_SEQ;
    end else if (nvmCorrupt) begin
      newCode = `ALM_NVM;
    end else if (panicIn || panicCmd) begin
      newCode = `ALM_PANIC;
    end else if (limPos && limNeg) begin
      newCode = `ALM_LS_LOGIC;
    end else if (drvAlm) begin
      newCode = `ALM_DRV_ALM;
    end else if (drvTimeout) begin
      newCode = `ALM_DRV_CONN;
    end else if (homeSeekActive &&
                 (homeSeekDirPos ? limNeg : limPos)) begin
      newCode = `ALM_LS_REV;
    end else if (homeSeekActive && edgeCnt_q == `UNSTABLE_EDGES) begin
      newCode = `ALM_HOME_FAIL;
    end else if (homeSeekActive && seenPos_q && seenNeg_q &&
                 !seenHome_q) begin
      newCode = `ALM_HOME_MISS;
    end else if (homeSeekEnd && homeSeekType != `HTYPE_HOME &&
                 !coincide_q) begin
      newCode = `ALM_TIM_SENS;
    end else if (offsetMoveActive && anyLim) begin
      newCode = `ALM_OFS_LS;
    end else if (anyLim && !homeSeekActive) begin
      newCode = `ALM_HW_OT;
    end else if (moveStart && (!currentEnabled || homeInputsMissing ||
                 linkDirMixed)) begin
      newCode = `ALM_MOT_PARAM;
    end else if (softOut) begin
      newCode = `ALM_SW_OT;
    end else begin
      newValid = 1'b0;
    end
  end

  // ==========================================================
  // Alarm latch
  assign fatalCur = alarmActive_q &&
                    (alarmCode_q == `ALM_NVM || alarmCode_q[7:4] == 4'hF);
  reg [7:0] code_d;
  reg active_d;

  always @* begin
    code_d = alarmCode_q;
    active_d = alarmActive_q;
    if (newValid && (!alarmActive_q || (newFatal && !fatalCur))) begin
      code_d = newCode;
      active_d = 1'b1;
    end else if (newValid) begin
      active_d = 1'b1;
    end else if (sysResetCmd) begin
      code_d = 8'h00;
      active_d = 1'b0;
    end else if (clearCmd && !fatalCur) begin
      code_d = 8'h00;
      active_d = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarmCode_q <= 8'h00;
      alarmActive_q <= 1'b0;
      motionHalt_q <= 1'b0;
      sequenceStop_q <= 1'b0;
      holdTorque_q <= 1'b1;
    end else begin
      alarmCode_q <= code_d;
      alarmActive_q <= active_d;
      motionHalt_q <= active_d;
      sequenceStop_q <= active_d;
      if (!active_d) begin
        holdTorque_q <= 1'b1;
      end else if (code_d == `ALM_NVM || code_d[7:4] == 4'hF) begin
        holdTorque_q <= 1'b0;
      end else if (code_d == `ALM_PANIC || code_d == `ALM_HW_OT ||
                   code_d == `ALM_SW_OT) begin
        holdTorque_q <= alarmStopAction;
      end else begin
        holdTorque_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Alarm LED
  localparam [4:0] S_DARK = 5'h01;
  localparam [4:0] S_ON = 5'h02;
  localparam [4:0] S_OFF = 5'h04;
  localparam [4:0] S_PAUSE = 5'h08;
  localparam [4:0] S_STEADY = 5'h10;
  reg [4:0] ledState_q;
  reg [31:0] ledTimer_q;
  reg [3:0] blinkLeft_q;
  reg [3:0] blinkCount;
  wire steady = alarmActive_q && alarmCode_q[7:4] == 4'hF;

  always @* begin
    if (alarmCode_q == `ALM_NVM) begin
      blinkCount = `BLINK_NVM;
    end else if (alarmCode_q == `ALM_PANIC) begin
      blinkCount = `BLINK_PANIC;
    end else if (alarmCode_q == `ALM_HW_OT ||
                 alarmCode_q == `ALM_SW_OT) begin
      blinkCount = `BLINK_OT;
    end else begin
      blinkCount = `BLINK_STOP;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ledState_q <= S_DARK;
      ledTimer_q <= 32'h00000000;
      blinkLeft_q <= 4'h0;
      alarmLed_q <= 1'b0;
    end else if (!alarmActive_q) begin
      ledState_q <= S_DARK;
      ledTimer_q <= 32'h00000000;
      alarmLed_q <= 1'b0;
    end else if (steady) begin
      ledState_q <= S_STEADY;
      alarmLed_q <= 1'b1;
    end else begin
      ledTimer_q <= ledTimer_q + 32'h00000001;
      case (ledState_q)
        S_ON: begin
          if (ledTimer_q == LED_ON_CYC - 1) begin
            ledState_q <= S_OFF;
            ledTimer_q <= 32'h00000000;
            alarmLed_q <= 1'b0;
          end
        end
        S_OFF: begin
          if (ledTimer_q == LED_OFF_CYC - 1) begin
            ledTimer_q <= 32'h00000000;
            if (blinkLeft_q == 4'h1) begin
              ledState_q <= S_PAUSE;
            end else begin
              ledState_q <= S_ON;
              blinkLeft_q <= blinkLeft_q - 4'h1;
              alarmLed_q <= 1'b1;
            end
          end
        end
        S_PAUSE: begin
          if (ledTimer_q == LED_PAUSE_CYC - 1) begin
            ledState_q <= S_ON;
            ledTimer_q <= 32'h00000000;
            blinkLeft_q <= blinkCount;
            alarmLed_q <= 1'b1;
          end
        end
        default: begin
          ledState_q <= S_ON;
          ledTimer_q <= 32'h00000000;
          blinkLeft_q <= blinkCount;
          alarmLed_q <= 1'b1;
        end
      endcase
    end
  end
endmodule

// File: test/motion_alarm_monitor_sva.sv
`timescale 1ns/1ps
// ==========================================================
// Alarm monitor checker
module motion_alarm_monitor_sva (
  // Clock and reset
  input wire clk,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // Faults
  input wire driverAlarm,
  input wire panicCmd,
  input wire nvmCorrupt,
  input wire logicStateFault,
  input wire memAccessFault,
  input wire seqCodeFault,
  // Alarm outputs
  input wire [7:0] alarmCode_q,
  input wire alarmActive_q,
  input wire motionHalt_q,
  input wire sequenceStop_q,
  input wire holdTorque_q,
  input wire driverCmdCancel_q,
  input wire alarmLed_q
);
  wire fatalNow = alarmActive_q &&
    (alarmCode_q == 8'h41 || alarmCode_q[7:4] == 4'hF);
  wire fatalIn = nvmCorrupt | logicStateFault | memAccessFault | seqCodeFault;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence setupS; psel && !penable; endsequence
  sequence clearWr;
    psel && penable && pready && pwrite && paddr == 12'h004 &&
    pwdata[1:0] == 2'h1;
  endsequence
  sequence steadyS; (fatalNow && alarmCode_q[7:4] == 4'hF) [*4]; endsequence
  halt_tracks_alarm_a: assert property (
    motionHalt_q == alarmActive_q && sequenceStop_q == alarmActive_q)
    else $error("halt flags differ from alarm");
  driver_alarm_latch_a: assert property (
    $rose(driverAlarm) && !alarmActive_q |-> ##[1:4] alarmActive_q)
    else $error("driver alarm not latched");
  panic_code_a: assert property (
    $rose(panicCmd) && !alarmActive_q && !fatalIn
    |=> alarmCode_q == 8'h68) else $error("panic code wrong");
  fatal_override_a: assert property (
    $rose(logicStateFault) && !fatalNow |=> alarmCode_q == 8'hF0)
    else $error("system error code wrong");
  fatal_torque_a: assert property (fatalNow |-> !holdTorque_q)
    else $error("torque held on fatal alarm");
  steady_led_a: assert property (steadyS |-> alarmLed_q)
    else $error("LED not steady");
  dark_idle_a: assert property (
    (!alarmActive_q) [*4] |-> !alarmLed_q)
    else $error("LED lit without alarm");
  clear_spares_a: assert property (
    clearWr ##0 fatalNow |=> alarmActive_q && $stable(alarmCode_q))
    else $error("clear removed fatal alarm");
  cancel_pulse_a: assert property (
    driverCmdCancel_q |=> !driverCmdCancel_q)
    else $error("cancel longer than one cycle");
  apb_answer_a: assert property (setupS |=> pready ##1 !pready)
    else $error("ready timing wrong");
endmodule

bind motion_alarm_monitor motion_alarm_monitor_sva i_sva (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .driverAlarm, .panicCmd, .nvmCorrupt, .logicStateFault, .memAccessFault,
  .seqCodeFault, .alarmCode_q, .alarmActive_q, .motionHalt_q,
  .sequenceStop_q, .holdTorque_q, .driverCmdCancel_q, .alarmLed_q);

// File: test/axis_side_model.sv
`timescale 1ns/1ps
// ==========================================================
// Driver response and limit sensor model
module axis_side_model (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Scenario controls
  input wire pol,
  input wire limPos,
  input wire limNeg,
  input wire [3:0] ackDelay,
  // Driver command
  input wire driverCmdIssue,
  // Pins
  output wire travelLimitPos,
  output wire travelLimitNeg,
  output logic driverAck
);
  logic [3:0] cnt_q;
  // Closed sensors idle high
  assign travelLimitPos = limPos ^ pol;
  assign travelLimitNeg = limNeg ^ pol;
  // Answer after ackDelay cycles, never when zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      driverAck <= 1'b0;
    end else begin
      driverAck <= (cnt_q == 4'h1);
      if (driverCmdIssue && ackDelay != 4'h0) cnt_q <= ackDelay;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule

// File: test/motion_alarm_monitor_bench.sv
`timescale 1ns/1ps
module motion_alarm_monitor_bench;
  typedef struct packed {
    logic [3:0] src; logic [4:0] ctrl; logic [7:0] code;
    logic [3:0] nb; logic tq;
  } row_t;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rdErr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, commandedPos = 32'h0, rd;
  logic homePositionSensor = 0, stepTimingSignal = 0, sensorInput = 0;
  logic driverAlarm = 0, panicHaltRequest = 0, homeSeekActive = 0;
  logic homeSeekDirPos = 0, homeSeekEnd = 0, offsetMoveActive = 0;
  logic driverCmdIssue = 0, moveStart = 0, currentEnabled = 1;
  logic homeInputsMissing = 0, linkDirMixed = 0, panicCmd = 0;
  logic nvmCorrupt = 0, logicStateFault = 0, memAccessFault = 0;
  logic seqCodeFault = 0, pol = 0, limPos = 0, limNeg = 0;
  logic [3:0] ackDelay = 4'h2;
  wire [31:0] prdata;
  wire [7:0] alarmCode_q;
  wire pready, pslverr, travelLimitPos, travelLimitNeg, driverAck;
  wire alarmActive_q, motionHalt_q, sequenceStop_q, holdTorque_q;
  wire driverCmdCancel_q, alarmLed_q;
  int failures = 0, checked = 0, cycles = 0, cancels = 0, n, i;
  logic [7:0] fc [4] = '{8'h41, 8'hF0, 8'hF1, 8'hF2};
  row_t rows [17] = '{
    '{4'h0, 5'h00, 8'h60, 4'h7, 1'b1}, '{4'h1, 5'h00, 8'h6E, 4'h7, 1'b1},
    '{4'h2, 5'h00, 8'h68, 4'h6, 1'b0}, '{4'h3, 5'h08, 8'h68, 4'h6, 1'b1},
    '{4'h4, 5'h01, 8'h66, 4'h7, 1'b0}, '{4'h5, 5'h00, 8'h70, 4'h7, 1'b1},
    '{4'h6, 5'h10, 8'h67, 4'h7, 1'b0}, '{4'h7, 5'h00, 8'h61, 4'h7, 1'b1},
    '{4'h8, 5'h00, 8'h6A, 4'h7, 1'b1}, '{4'h9, 5'h00, 8'h6F, 4'h7, 1'b1},
    '{4'hA, 5'h02, 8'h64, 4'h7, 1'b1}, '{4'hB, 5'h00, 8'h70, 4'h7, 1'b1},
    '{4'hC, 5'h00, 8'h70, 4'h7, 1'b1}, '{4'hD, 5'h00, 8'h62, 4'h7, 1'b1},
    '{4'hE, 5'h00, 8'h63, 4'h7, 1'b1}, '{4'hA, 5'h04, 8'h64, 4'h7, 1'b1},
    '{4'hA, 5'h06, 8'h64, 4'h7, 1'b1}};
  motion_alarm_monitor #(.LED_ON_CYC(4), .LED_OFF_CYC(3), .LED_PAUSE_CYC(10),
    .DRV_TIMEOUT_CYC(8)) i_motion_alarm_monitor (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .travelLimitPos, .travelLimitNeg, .homePositionSensor, .stepTimingSignal,
    .sensorInput, .driverAlarm, .driverAck, .panicHaltRequest,
    .homeSeekActive, .homeSeekDirPos, .homeSeekEnd, .offsetMoveActive,
    .driverCmdIssue, .moveStart, .currentEnabled, .homeInputsMissing,
    .linkDirMixed, .panicCmd, .commandedPos, .nvmCorrupt, .logicStateFault,
    .memAccessFault, .seqCodeFault, .alarmCode_q, .alarmActive_q,
    .motionHalt_q, .sequenceStop_q, .holdTorque_q, .driverCmdCancel_q,
    .alarmLed_q);
  axis_side_model i_axis_side_model (.clk, .rst, .pol, .limPos, .limNeg,
    .ackDelay, .driverCmdIssue, .travelLimitPos, .travelLimitNeg, .driverAck);
  always #50 clk = ~clk;
  // ==========================================================
  // Tasks
  task wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (driverCmdCancel_q === 1'b1) cancels++;
    if (cycles == 20000) begin
      failures++;
      wrap_up;
    end
  end
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wait_c(input int k);
    repeat (k) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rs;
    apb(1'b0, 12'h008, 32'h0);
  endtask
  task idle;
    @(posedge clk);
    {limPos, limNeg, driverAlarm, panicCmd, panicHaltRequest} <= 5'h0;
    {homeSeekActive, homeSeekDirPos, offsetMoveActive} <= 3'h0;
    {homeInputsMissing, linkDirMixed, homePositionSensor} <= 3'h0;
    currentEnabled <= 1'b1; commandedPos <= 32'h0; ackDelay <= 4'h2;
  endtask
  task blinks(output int c);
    int dark, k;
    logic prev;
    c = 0; dark = 0; prev = 0;
    for (k = 0; k < 300 && dark < 8; k++) begin
      @(posedge clk);
      dark = alarmLed_q ? 0 : dark + 1;
    end
    dark = 0;
    for (k = 0; k < 300 && dark < 8; k++) begin
      @(posedge clk);
      if (alarmLed_q && !prev) c++;
      prev = alarmLed_q;
      dark = alarmLed_q ? 0 : dark + 1;
    end
  endtask
  task apply(input logic [3:0] s);
    if (s == 4'h6) apb(1'b1, 12'h00C, 32'h64);
    @(posedge clk);
    case (s)
      0: {limPos, limNeg} <= 2'h3;
      1: driverAlarm <= 1'b1;
      2: panicCmd <= 1'b1;
      3: panicHaltRequest <= 1'b1;
      4: limPos <= 1'b1;
      5: {currentEnabled, moveStart} <= 2'h1;
      6: commandedPos <= 32'hC8;
      7: {homeSeekActive, homeSeekDirPos, limNeg} <= 3'h7;
      8: {offsetMoveActive, limPos} <= 2'h3;
      9: {ackDelay, driverCmdIssue} <= 5'h01;
      10: {homeSeekActive, homePositionSensor, homeSeekEnd} <= 3'h7;
      11: {homeInputsMissing, moveStart} <= 2'h3;
      12: {linkDirMixed, moveStart} <= 2'h3;
      default: begin
        {homeSeekActive, homeSeekDirPos} <= 2'h3;
        for (n = 0; n < 3; n++) begin
          wait_c(4); limPos <= 1'b1;
          wait_c(4); limPos <= 1'b0;
          if (s == 4'hE && n == 0) begin
            wait_c(4); homeSeekDirPos <= 1'b0; limNeg <= 1'b1;
            n = 3;
          end
        end
      end
    endcase
    @(posedge clk);
    {moveStart, driverCmdIssue, homeSeekEnd} <= 3'h0;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    wait_c(6);
    rst <= 1'b0;
    rs; chk("status reset", rd, 32'h200);
    apb(1'b0, 12'h000, 32'h0); chk("ctrl reset", rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0); chk("pos limit", rd, 32'h7FFFFFFF);
    apb(1'b0, 12'h010, 32'h0); chk("neg limit", rd, 32'h80000000);
    apb(1'b0, 12'h020, 32'h0); chk("unmapped", rd, 32'h0);
    chk("unmapped error", {31'h0, rdErr}, 32'h1);
    foreach (rows[r]) begin
      idle;
      pol <= rows[r].ctrl[0];
      apb(1'b1, 12'h000, {27'h0, rows[r].ctrl});
      wait_c(5); apb(1'b1, 12'h004, 32'h1); wait_c(3);
      rs; chk("idle", rd, 32'h200);
      apply(rows[r].src);
      wait_c(8); rs;
      chk("alarm", rd, {22'h0, rows[r].tq, 1'b1, rows[r].code});
      chk("halt", {motionHalt_q, sequenceStop_q}, 2'h3);
      blinks(n); chk("blinks", 32'(n), rows[r].nb);
      idle; wait_c(5); apb(1'b1, 12'h004, 32'h1); wait_c(3);
      rs; chk("cleared", rd, 32'h200);
    end
    chk("cancel pulses", 32'(cancels), 32'h1);
    // Prompt driver answer raises nothing
    @(posedge clk) driverCmdIssue <= 1'b1;
    @(posedge clk) driverCmdIssue <= 1'b0;
    wait_c(20); rs; chk("prompt ack", rd, 32'h200);
    // Clear while the fault persists
    driverAlarm <= 1'b1; wait_c(6); apb(1'b1, 12'h004, 32'h1); rs;
    chk("set wins", rd, 32'h36E);
    idle; wait_c(5); apb(1'b1, 12'h004, 32'h1);
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      {seqCodeFault, memAccessFault, logicStateFault, nvmCorrupt} <= 4'h1 << i;
      @(posedge clk);
      {seqCodeFault, memAccessFault, logicStateFault, nvmCorrupt} <= 4'h0;
      wait_c(4); apb(1'b1, 12'h004, 32'h1); rs;
      chk("fatal", rd, {21'h0, 3'h5, fc[i]});
      if (i == 0) begin
        blinks(n); chk("nvm blinks", 32'(n), 32'h9);
      end else begin
        wait_c(4); chk("steady", {31'h0, alarmLed_q}, 32'h1);
      end
      apb(1'b1, 12'h004, 32'h2); wait_c(3);
      rs; chk("system reset", rd, 32'h200);
    end
    // Mid-run reset clears a latched alarm
    nvmCorrupt <= 1'b1; wait_c(3); nvmCorrupt <= 1'b0;
    chk("nvm latched", {31'h0, alarmActive_q}, 32'h1);
    rst <= 1'b1; wait_c(2); rst <= 1'b0;
    rs; chk("reset clears", rd, 32'h200);
    wrap_up;
  end
endmodule
